/* pkg/ppctl_pkg.sv */
// Package with register map, field positions and carriers for the printer port pin control
package ppctl_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PPCTL_OFF_PORT_CONFIG = 8'h00;
   localparam logic [7:0] PPCTL_OFF_PWR_MGMT    = 8'h04;
   localparam logic [7:0] PPCTL_OFF_FUNC_CTRL   = 8'h08;
   localparam logic [7:0] PPCTL_OFF_PORT_CTRL   = 8'h0c;
   localparam logic [7:0] PPCTL_OFF_STATUS      = 8'h10;
   localparam logic [7:0] PPCTL_OFF_IRQ_STAT    = 8'h14;
   localparam logic [7:0] PPCTL_OFF_IRQ_MASK    = 8'h18;
   localparam logic [7:0] PPCTL_OFF_DMA_CTRL    = 8'h1c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PPCTL_PCFG_ECP_EN  = 2;
   localparam int PPCTL_PMC_DMA_EN   = 3;
   localparam int PPCTL_FCR_PNF_EN   = 2;
   localparam int PPCTL_PCTL_PRINTER_SELECT_OUT_N    = 3;
   localparam int PPCTL_PCTL_IRQ_EN  = 4;
   localparam int PPCTL_DMA_REQ      = 0;
   localparam int PPCTL_DMA_IRQ_ADDR = 1;
   // Status word bits
   localparam int PPCTL_ST_PAPER     = 0;
   localparam int PPCTL_ST_SELECTED  = 1;
   localparam int PPCTL_ST_PRINTER   = 2;
   localparam int PPCTL_ST_SECOND_DRIVE_PRESENT_IN      = 3;
   localparam int PPCTL_ST_STRAP     = 4;
   localparam int PPCTL_ST_ACK_EFF   = 5;
   localparam int PPCTL_ST_DMA_XFER  = 6;
   localparam int PPCTL_ST_FLOP_RD   = 7;
   // Interrupt event bits
   localparam int PPCTL_EV_PAPER     = 0;
   localparam int PPCTL_EV_SELECTED  = 1;
   localparam int PPCTL_EV_DMA_XFER  = 2;
   localparam int PPCTL_EV_W         = 3;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  PPCTL_RST_PCFG = 8'h00;
   localparam logic [7:0]  PPCTL_RST_PMC  = 8'h00;
   localparam logic [7:0]  PPCTL_RST_FCR  = 8'h00;
   localparam logic [7:0]  PPCTL_RST_PCTL = 8'h00;
   localparam logic [7:0]  PPCTL_RST_DMA  = 8'h00;
   localparam logic [31:0] PPCTL_BAD_DATA = 32'h0000_0000;
   localparam int PPCTL_CLK_PS      = 5000;
   localparam int PPCTL_PRINTER_SELECT_OUT_N_REL_PS = 10000;
   localparam int PPCTL_PRINTER_SELECT_OUT_N_REL_CYC = (PPCTL_PRINTER_SELECT_OUT_N_REL_PS / PPCTL_CLK_PS < 1) ? 1
                                       : PPCTL_PRINTER_SELECT_OUT_N_REL_PS / PPCTL_CLK_PS;
   localparam logic [1:0] PPCTL_RESP_OKAY   = 2'b00;
   localparam logic [1:0] PPCTL_RESP_SLVERR = 2'b10;

   // Printer-side pin bundle
   typedef struct packed {
      logic paper_out_in;
      logic printer_selected_in;
      logic ack_n;
      logic floppy_rdata;
   } ppctl_pins_t;

   // Pin driver bundle: value and active-low enable
   typedef struct packed {
      logic o;
      logic oe_n;
   } ppctl_drv_t;

   // Write-path state
   typedef enum logic [2:0] {
      PPCTL_W_IDLE = 3'b001,
      PPCTL_W_RESP = 3'b010,
      PPCTL_W_HOLD = 3'b100
   } ppctl_wst_t;

endpackage

/* test/ppctl_assertions.sv */
// Concurrent checks on the pin outputs of the printer port pin control
`timescale 1ns/1ps
module ppctl_assertions (
   input wire logic clk, rst_b, ecp_mode, host_rd_n, host_wr_n, ack_in_n,
   input wire logic shared_rdata_in, printer_vs_floppy_sel, printer_dma_req,
   input wire logic printer_select_out_n, port_irq, port_irq_oe_n,
   input wire logic dma_rd_strobe, dma_wr_strobe, floppy_rdata, shared_floppy_pin_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------------------------------
   // Pin relations, allowing three edges of pin latency
   // ----------------------------------------------------------------
   a_rd_idle: assert property (host_rd_n [*4] |-> !dma_rd_strobe)
      else $error("dma read strobe without host read");
   a_wr_idle: assert property (host_wr_n [*4] |-> !dma_wr_strobe)
      else $error("dma write strobe without host write");
   a_ack_ecp_only: assert property (!ecp_mode [*4] |-> !dma_rd_strobe && !dma_wr_strobe)
      else $error("acknowledge honoured outside ecp");
   a_req_ecp_only: assert property (!ecp_mode [*4] |-> !printer_dma_req)
      else $error("dma request outside ecp");
   a_sel_low: assert property (printer_select_out_n == 1'h0)
      else $error("select-in value not low");
   a_printer_use: assert property (printer_vs_floppy_sel [*4] |-> !shared_floppy_pin_mode)
      else $error("floppy use with selector high");
   a_floppy_off: assert property (!shared_floppy_pin_mode [*2] |-> !floppy_rdata)
      else $error("floppy data leaks in printer use");
   a_floppy_data: assert property ((shared_floppy_pin_mode && $stable(shared_rdata_in)) [*4]
      |-> floppy_rdata == shared_rdata_in)
      else $error("floppy data not passed");
   a_irq_follow: assert property ((!port_irq_oe_n && $stable(ack_in_n)) [*4]
      |-> port_irq == ack_in_n)
      else $error("port interrupt not following acknowledge");
endmodule
bind ppctl_top ppctl_assertions i_chk (.clk, .rst_b, .ecp_mode, .host_rd_n, .host_wr_n, .ack_in_n,
   .shared_rdata_in, .printer_vs_floppy_sel, .printer_dma_req, .printer_select_out_n, .port_irq,
   .port_irq_oe_n, .dma_rd_strobe, .dma_wr_strobe, .floppy_rdata, .shared_floppy_pin_mode);

/* test/ppctl_printer_model.sv */
// Behavioural printer or floppy drive on the shared port pins
`timescale 1ns/1ps
module ppctl_printer_model (
   input wire logic clk, attached, floppy, paper_empty, ack_lvl, disk_bit,
   input wire logic printer_select_out_n, printer_select_oe_n,
   output logic     paper_out_in, printer_selected_in, ack_in_n, shared_rdata_in,
   output logic     printer_vs_floppy_sel, select_wire
);
   logic tog_q = 1'h0;
   // Status lines, pull-downs win when nothing drives them
   always_comb begin
      paper_out_in = attached && !floppy && paper_empty;
      printer_selected_in = attached && !floppy;
      printer_vs_floppy_sel = !floppy;
      ack_in_n = floppy ? 1'h1 : ack_lvl;
      select_wire = printer_select_oe_n ? 1'h1 : printer_select_out_n; // Pull-up when released
   end
   // Disk data only in floppy use, a toggling line otherwise
   always @(posedge clk) tog_q <= !tog_q;
   assign shared_rdata_in = floppy ? disk_bit : tog_q;
endmodule

/* test/ppctl_top_tb.sv */
// Register-level testbench of the printer port pin control
`timescale 1ns/1ps
module ppctl_top_tb;
   import ppctl_pkg::*;
   logic clk = 1'h0, rst_b = 1'h0, shared_ack_strap_in = 1'h1, host_rd_n = 1'h1, host_wr_n = 1'h1;
   logic ecp_mode = 1'h0, attached = 1'h0, floppy = 1'h0, paper_empty = 1'h0, ack_lvl = 1'h1, disk_bit = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic paper_out_in, printer_selected_in, ack_in_n, shared_rdata_in, printer_vs_floppy_sel, select_wire;
   logic printer_dma_req, printer_dma_req_oe_n, printer_select_out_n, printer_select_oe_n, port_irq;
   logic port_irq_oe_n, dma_rd_strobe, dma_wr_strobe, floppy_rdata, shared_floppy_pin_mode, irq;
   int err_count = 0;
   int samples_checked = 0;
   ppctl_top i_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .shared_ack_strap_in, .printer_vs_floppy_sel, .paper_out_in, .printer_selected_in,
      .ack_in_n, .shared_rdata_in, .host_rd_n, .host_wr_n, .ecp_mode, .printer_dma_req,
      .printer_dma_req_oe_n, .printer_select_out_n, .printer_select_oe_n, .port_irq, .port_irq_oe_n,
      .dma_rd_strobe, .dma_wr_strobe, .floppy_rdata, .shared_floppy_pin_mode, .irq);
   ppctl_printer_model i_model (.clk, .attached, .floppy, .paper_empty, .ack_lvl, .disk_bit,
      .printer_select_out_n, .printer_select_oe_n, .paper_out_in, .printer_selected_in, .ack_in_n,
      .shared_rdata_in, .printer_vs_floppy_sel, .select_wire);
   always #2.5 clk = !clk;
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic tmo(input int n);
      if (n >= 200) begin
         chk("bus answer", 32'h1, 32'h0);
         print_verdict();
      end
   endtask
   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 200);
      tmo(n);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 200);
      tmo(n);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      wc(12);
      rst_b <= 1'h1;
      wc(4);
      chk("req_oe_n", 32'h1, printer_dma_req_oe_n);
      chk("sel_oe_n", 32'h1, printer_select_oe_n);
      chk("irq_oe_n", 32'h1, port_irq_oe_n);
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4));
         chk("reset value", (i == 4) ? 32'h3c : 32'h0, rd_data);
      end
      wr(8'h20, 32'h1);
      chk("unmapped bresp", 32'h2, resp);
      rd(8'h20);
      chk("unmapped rdata", 32'h0, rd_data);
      chk("unmapped rresp", 32'h2, resp);
      // Request enable over all ECP and DMA bit pairs
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {29'h0, i[1], 2'h0});
         wr(8'h04, {28'h0, i[0], 3'h0});
         chk("req_oe_n", {31'h0, !(i[1] && i[0])}, printer_dma_req_oe_n);
      end
      wr(8'h1c, 32'h1);
      ecp_mode <= 1'h1;
      wc(4);
      chk("dma_req", 32'h1, printer_dma_req);
      ecp_mode <= 1'h0;
      wc(4);
      chk("dma_req", 32'h0, printer_dma_req);
      // Acknowledge from the DMA controller turns strobes into DMA
      ecp_mode <= 1'h1;
      shared_ack_strap_in <= 1'h0;
      host_rd_n <= 1'h0;
      wc(4);
      chk("rd_strobe", 32'h1, dma_rd_strobe);
      rd(8'h10);
      chk("strap_eff", 32'h1, {31'h0, rd_data[4]});
      chk("ack_eff", 32'h0, {31'h0, rd_data[5]});
      host_rd_n <= 1'h1;
      host_wr_n <= 1'h0;
      wc(4);
      chk("wr_strobe", 32'h1, dma_wr_strobe);
      ecp_mode <= 1'h0;
      wc(4);
      chk("wr_strobe", 32'h0, dma_wr_strobe);
      ecp_mode <= 1'h1;
      wr(8'h04, 32'h0);
      wc(3);
      chk("wr_strobe", 32'h0, dma_wr_strobe);
      rd(8'h10);
      chk("strap_eff", 32'h0, {31'h0, rd_data[4]});
      host_wr_n <= 1'h1;
      shared_ack_strap_in <= 1'h1;
      // Transfer event: masked, unmasked, cleared
      rd(8'h14);
      chk("irq_stat", 32'h4, rd_data);
      chk("irq", 32'h0, irq);
      wr(8'h18, 32'h4);
      wc(2);
      chk("irq", 32'h1, irq);
      wr(8'h14, 32'h4);
      wc(2);
      chk("irq", 32'h0, irq);
      // Printer status inputs
      attached <= 1'h1;
      paper_empty <= 1'h1;
      wc(4);
      rd(8'h10);
      chk("paper_out", 32'h1, {31'h0, rd_data[0]});
      chk("selected", 32'h1, {31'h0, rd_data[1]});
      rd(8'h14);
      chk("irq_stat", 32'h3, rd_data);
      // Floppy use of the shared pins
      floppy <= 1'h1;
      wc(4);
      chk("pin_mode", 32'h0, shared_floppy_pin_mode);
      rd(8'h10);
      chk("drive2", 32'h0, {31'h0, rd_data[3]});
      wr(8'h08, 32'h4);
      wc(2);
      chk("pin_mode", 32'h1, shared_floppy_pin_mode);
      for (int i = 1; i >= 0; i--) begin
         disk_bit <= i[0];
         wc(4);
         chk("floppy_rdata", {31'h0, i[0]}, floppy_rdata);
      end
      floppy <= 1'h0;
      wc(4);
      chk("pin_mode", 32'h0, shared_floppy_pin_mode);
      // Select-in drive and release
      wr(8'h0c, 32'h8);
      chk("select_wire", 32'h0, select_wire);
      wr(8'h0c, 32'h0);
      chk("select_wire", 32'h1, select_wire);
      // Port interrupt enable and follow
      wr(8'h1c, 32'h3);
      wr(8'h0c, 32'h10);
      wc(2);
      chk("irq_oe_n", 32'h0, port_irq_oe_n);
      ack_lvl <= 1'h0;
      wc(4);
      chk("port_irq", 32'h0, port_irq);
      wr(8'h1c, 32'h1);
      wc(2);
      chk("irq_oe_n", 32'h1, port_irq_oe_n);
      print_verdict();
   end
endmodule

/* verilog/ppctl_top.sv */
// Printer port pin control with AXI4-Lite register slave
`timescale 1ns/1ps
module ppctl_top
   import ppctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pins
   input  wire logic        shared_ack_strap_in,
   input  wire logic        printer_vs_floppy_sel,
   input  wire logic        paper_out_in,
   input  wire logic        printer_selected_in,
   input  wire logic        ack_in_n,
   input  wire logic        shared_rdata_in,
   input  wire logic        host_rd_n,
   input  wire logic        host_wr_n,
   input  wire logic        ecp_mode,
   output logic             printer_dma_req,
   output logic             printer_dma_req_oe_n,
   output logic             printer_select_out_n,
   output logic             printer_select_oe_n,
   output logic             port_irq,
   output logic             port_irq_oe_n,
   output logic             dma_rd_strobe,
   output logic             dma_wr_strobe,
   output logic             floppy_rdata,
   output logic             shared_floppy_pin_mode,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] meta_q, sync_q, raw;
   assign raw = {shared_ack_strap_in, printer_vs_floppy_sel, paper_out_in, printer_selected_in,
                 ack_in_n, shared_rdata_in, host_rd_n, host_wr_n, ecp_mode};

   // Two-stage capture of every pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   logic shared_s, pnf_s, rd_n_s, wr_n_s, ecp_s;
   ppctl_pins_t pins;
   assign shared_s = sync_q[8];
   assign pnf_s    = sync_q[7];
   assign pins     = '{paper_out_in: sync_q[6], printer_selected_in: sync_q[5],
                       ack_n: sync_q[4], floppy_rdata: sync_q[3]};
   assign rd_n_s   = sync_q[2];
   assign wr_n_s   = sync_q[1];
   assign ecp_s    = sync_q[0];

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] port_config_reg_q, port_config_reg_d;
   logic [7:0] power_mgmt_ctrl_reg_q, power_mgmt_ctrl_reg_d;
   logic [7:0] function_ctrl_reg_q, function_ctrl_reg_d;
   logic [7:0] port_ctrl_q, port_ctrl_d;
   logic [7:0] dma_ctrl_q, dma_ctrl_d;
   logic [PPCTL_EV_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;

   // Byte-lane merge of a write into an 8-bit register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
      merge8 = st[0] ? wd[7:0] : old;
   endfunction

   // ----------------------------------------------------------------
   // Pin function decoding
   // ----------------------------------------------------------------
   logic dma_cfg, ecp_en, ack_eff_n, strap_eff, printer_mode, second_drive_present_in_eff, dma_xfer;
   assign dma_cfg      = power_mgmt_ctrl_reg_q[PPCTL_PMC_DMA_EN];
   assign ecp_en       = port_config_reg_q[PPCTL_PCFG_ECP_EN];
   // Shared pin is acknowledge or strap; idle role reads one
   assign ack_eff_n    = (dma_cfg && ecp_s) ? shared_s : 1'b1;
   assign strap_eff    = dma_cfg ? 1'b1 : shared_s;
   // Selector pin is printer/floppy choice or second-drive input
   assign printer_mode = function_ctrl_reg_q[PPCTL_FCR_PNF_EN] ? pnf_s : 1'b1;
   assign second_drive_present_in_eff     = function_ctrl_reg_q[PPCTL_FCR_PNF_EN] ? 1'b0 : pnf_s;
   assign dma_xfer     = !ack_eff_n && (!rd_n_s || !wr_n_s);

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   ppctl_wst_t wst_q, wst_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic        bvalid_d;
   logic [1:0]  bresp_d;
   logic        do_write;
   assign do_write = (wst_q == PPCTL_W_IDLE) && aw_have_q && w_have_q;

   // Collect address and data in either order, then answer
   always_comb begin
      wst_d     = wst_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      bvalid_d  = s_axi_bvalid;
      bresp_d   = s_axi_bresp;
      unique case (wst_q)
         PPCTL_W_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               awaddr_d  = s_axi_awaddr;
               aw_have_d = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               wdata_d  = s_axi_wdata;
               wstrb_d  = s_axi_wstrb;
               w_have_d = 1'b1;
            end
            if (do_write) begin
               wst_d    = PPCTL_W_RESP;
               bvalid_d = 1'b1;
               bresp_d  = (awaddr_q > PPCTL_OFF_DMA_CTRL || awaddr_q[1:0] != 2'b00)
                          ? PPCTL_RESP_SLVERR : PPCTL_RESP_OKAY;
            end
         end
         PPCTL_W_RESP: begin
            if (s_axi_bready) begin
               bvalid_d  = 1'b0;
               aw_have_d = 1'b0;
               w_have_d  = 1'b0;
               wst_d     = PPCTL_W_HOLD;
            end
         end
         PPCTL_W_HOLD: wst_d = PPCTL_W_IDLE;
         default:      wst_d = PPCTL_W_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Register update and interrupt status
   // ----------------------------------------------------------------
   always_comb begin
      port_config_reg_d     = port_config_reg_q;
      power_mgmt_ctrl_reg_d = power_mgmt_ctrl_reg_q;
      function_ctrl_reg_d   = function_ctrl_reg_q;
      port_ctrl_d           = port_ctrl_q;
      dma_ctrl_d            = dma_ctrl_q;
      irq_mask_d            = irq_mask_q;
      irq_stat_d            = irq_stat_q;
      if (do_write) begin
         unique case (awaddr_q)
            PPCTL_OFF_PORT_CONFIG: port_config_reg_d     = merge8(port_config_reg_q, wdata_q, wstrb_q);
            PPCTL_OFF_PWR_MGMT:    power_mgmt_ctrl_reg_d = merge8(power_mgmt_ctrl_reg_q, wdata_q, wstrb_q);
            PPCTL_OFF_FUNC_CTRL:   function_ctrl_reg_d   = merge8(function_ctrl_reg_q, wdata_q, wstrb_q);
            PPCTL_OFF_PORT_CTRL:   port_ctrl_d           = merge8(port_ctrl_q, wdata_q, wstrb_q);
            PPCTL_OFF_DMA_CTRL:    dma_ctrl_d            = merge8(dma_ctrl_q, wdata_q, wstrb_q);
            PPCTL_OFF_IRQ_MASK:    if (wstrb_q[0]) irq_mask_d = wdata_q[PPCTL_EV_W-1:0];
            PPCTL_OFF_IRQ_STAT:    if (wstrb_q[0]) irq_stat_d = irq_stat_q & ~wdata_q[PPCTL_EV_W-1:0];
            default: ;
         endcase
      end
      irq_stat_d = irq_stat_d | ev;   // Set wins over clear
   end

   // Rising-edge events on status levels
   logic paper_q, sel_q, xfer_q;
   always_comb begin
      ev = '0;
      ev[PPCTL_EV_PAPER]    = pins.paper_out_in && !paper_q;
      ev[PPCTL_EV_SELECTED] = pins.printer_selected_in && !sel_q;
      ev[PPCTL_EV_DMA_XFER] = dma_xfer && !xfer_q;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   logic [31:0] rdata_d, status_w;
   logic        rvalid_d, arready_d;
   logic [1:0]  rresp_d;
   assign status_w = {24'h00_0000, pins.floppy_rdata & ~printer_mode, dma_xfer, ack_eff_n, strap_eff,
                      second_drive_present_in_eff, printer_mode, pins.printer_selected_in, pins.paper_out_in};

   // One read at a time; answer one cycle after address taken
   always_comb begin
      rvalid_d  = s_axi_rvalid;
      rdata_d   = s_axi_rdata;
      rresp_d   = s_axi_rresp;
      arready_d = !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = PPCTL_RESP_OKAY;
         unique case (s_axi_araddr)
            PPCTL_OFF_PORT_CONFIG: rdata_d = {24'h00_0000, port_config_reg_q};
            PPCTL_OFF_PWR_MGMT:    rdata_d = {24'h00_0000, power_mgmt_ctrl_reg_q};
            PPCTL_OFF_FUNC_CTRL:   rdata_d = {24'h00_0000, function_ctrl_reg_q};
            PPCTL_OFF_PORT_CTRL:   rdata_d = {24'h00_0000, port_ctrl_q};
            PPCTL_OFF_STATUS:      rdata_d = status_w;
            PPCTL_OFF_IRQ_STAT:    rdata_d = {29'h0, irq_stat_q};
            PPCTL_OFF_IRQ_MASK:    rdata_d = {29'h0, irq_mask_q};
            PPCTL_OFF_DMA_CTRL:    rdata_d = {24'h00_0000, dma_ctrl_q};
            default: begin
               rdata_d = PPCTL_BAD_DATA;
               rresp_d = PPCTL_RESP_SLVERR;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   ppctl_drv_t req_d, printer_select_out_n_d, pirq_d;
   logic dma_rd_d, dma_wr_d, flop_d, irq_d;
   always_comb begin
      // Request drives only with ECP and DMA enabled
      req_d.o    = dma_ctrl_q[PPCTL_DMA_REQ] && ecp_s;
      req_d.oe_n = !(ecp_en && dma_cfg);
      // Select-in low when control bit set, released otherwise
      printer_select_out_n_d.o    = 1'b0;
      printer_select_out_n_d.oe_n = !port_ctrl_d[PPCTL_PCTL_PRINTER_SELECT_OUT_N];
      // Interrupt follows acknowledge when enabled
      pirq_d.o    = pins.ack_n;
      pirq_d.oe_n = !(port_ctrl_q[PPCTL_PCTL_IRQ_EN] && dma_ctrl_q[PPCTL_DMA_IRQ_ADDR]);
      dma_rd_d    = !ack_eff_n && !rd_n_s;
      dma_wr_d    = !ack_eff_n && !wr_n_s;
      flop_d      = printer_mode ? 1'b0 : pins.floppy_rdata;
      irq_d       = |(irq_stat_d & irq_mask_d);
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_config_reg_q     <= PPCTL_RST_PCFG;
         power_mgmt_ctrl_reg_q <= PPCTL_RST_PMC;
         function_ctrl_reg_q   <= PPCTL_RST_FCR;
         port_ctrl_q           <= PPCTL_RST_PCTL;
         dma_ctrl_q            <= PPCTL_RST_DMA;
         irq_stat_q            <= '0;
         irq_mask_q            <= '0;
         paper_q               <= 1'b1;   // Matches synchroniser reset, no false edge
         sel_q                 <= 1'b1;   // Matches synchroniser reset, no false edge
         xfer_q                <= 1'b0;
         wst_q                 <= PPCTL_W_IDLE;
         awaddr_q              <= 8'h00;
         wdata_q               <= 32'h0000_0000;
         wstrb_q               <= 4'h0;
         aw_have_q             <= 1'b0;
         w_have_q              <= 1'b0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= PPCTL_RESP_OKAY;
         s_axi_arready         <= 1'b0;
         s_axi_rvalid          <= 1'b0;
         s_axi_rdata           <= 32'h0000_0000;
         s_axi_rresp           <= PPCTL_RESP_OKAY;
         s_axi_awready         <= 1'b0;
         s_axi_wready          <= 1'b0;
         printer_dma_req       <= 1'b0;
         printer_dma_req_oe_n  <= 1'b1;
         printer_select_out_n  <= 1'b0;
         printer_select_oe_n   <= 1'b1;
         port_irq              <= 1'b0;
         port_irq_oe_n         <= 1'b1;
         dma_rd_strobe         <= 1'b0;
         dma_wr_strobe         <= 1'b0;
         floppy_rdata          <= 1'b0;
         shared_floppy_pin_mode <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         port_config_reg_q     <= port_config_reg_d;
         power_mgmt_ctrl_reg_q <= power_mgmt_ctrl_reg_d;
         function_ctrl_reg_q   <= function_ctrl_reg_d;
         port_ctrl_q           <= port_ctrl_d;
         dma_ctrl_q            <= dma_ctrl_d;
         irq_stat_q            <= irq_stat_d;
         irq_mask_q            <= irq_mask_d;
         paper_q               <= pins.paper_out_in;
         sel_q                 <= pins.printer_selected_in;
         xfer_q                <= dma_xfer;
         wst_q                 <= wst_d;
         awaddr_q              <= awaddr_d;
         wdata_q               <= wdata_d;
         wstrb_q               <= wstrb_d;
         aw_have_q             <= aw_have_d;
         w_have_q              <= w_have_d;
         s_axi_bvalid          <= bvalid_d;
         s_axi_bresp           <= bresp_d;
         s_axi_arready         <= arready_d;
         s_axi_rvalid          <= rvalid_d;
         s_axi_rdata           <= rdata_d;
         s_axi_rresp           <= rresp_d;
         s_axi_awready         <= (wst_d == PPCTL_W_IDLE) && !aw_have_d;
         s_axi_wready          <= (wst_d == PPCTL_W_IDLE) && !w_have_d;
         printer_dma_req       <= req_d.o;
         printer_dma_req_oe_n  <= req_d.oe_n;
         printer_select_out_n  <= printer_select_out_n_d.o;
         printer_select_oe_n   <= printer_select_out_n_d.oe_n;
         port_irq              <= pirq_d.o;
         port_irq_oe_n         <= pirq_d.oe_n;
         dma_rd_strobe         <= dma_rd_d;
         dma_wr_strobe         <= dma_wr_d;
         floppy_rdata          <= flop_d;
         shared_floppy_pin_mode <= !printer_mode;
         irq                   <= irq_d;
      end
   end

endmodule
